/* File: core/tsp_regs.sv */
// Pointer-addressed register file of the on-card thermometer and thermostat.
`timescale 1ns/1ps

// Contract
// RULE1: Pointer 0..3 selects temp, config, upper, lower.
// RULE2: Config is 8 bits, others 16 bits.
// RULE3: Data moves most significant bit first.
// RULE4: Temperatures are two's complement, sign in MSB.
// RULE5: All temperatures held in degrees Celsius.
// RULE6: Read returns the register the pointer selects.
// RULE7: Write loads the register the pointer selects.
// RULE8: Host programs limits, reads ambient temperature.
// RULE9: Host writes pointer before switching registers.
// RULE10: Pointer holds until host writes a new one.
module tsp_regs
  import tsp_pkg::*;
#(
  parameter int DATA_W = 16
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Host register port
  input wire logic [TSP_ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rd_data,
  // Measurement input
  input wire logic [TSP_WIDE_W-1:0] temp_sample,
  input wire logic temp_valid,
  // Thermostat and error flags
  output logic over_temp,
  output logic under_temp,
  output logic access_err
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (DATA_W != TSP_WIDE_W)
  begin : g_bad_width
    $error("tsp_regs: DATA_W must equal the 16-bit register width");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [TSP_PTR_W-1:0] ptr;
    logic [TSP_WIDE_W-1:0] temp;
    logic [TSP_CFG_W-1:0] cfg;
    logic [TSP_WIDE_W-1:0] upper;
    logic [TSP_WIDE_W-1:0] lower;
    logic [DATA_W-1:0] rdata;
    logic err;
    logic over;
    logic under;
  } tsp_state_s;

  tsp_state_s state_reg;
  tsp_state_s state_next;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic tsp_ptr_valid(input logic [TSP_PTR_W-1:0] p);
    return p < TSP_PTR_FIRST_RSVD;
  endfunction

  function automatic logic [4:0] tsp_width_code(input logic [TSP_PTR_W-1:0] p);
    logic [4:0] w;
    w = TSP_WIDTH_CODE_NONE;
    if (p == TSP_PTR_CFG)
    begin
      w = TSP_WIDTH_CODE_CFG;
    end
    else if (tsp_ptr_valid(p))
    begin
      w = TSP_WIDTH_CODE_WIDE;
    end
    return w;
  endfunction

  logic data_wr;
  logic data_rd;
  logic ptr_wr;
  logic stat_wr;
  logic stat_rd;

  assign data_wr = wr_en && (addr == TSP_ADDR_DATA);
  assign data_rd = rd_en && (addr == TSP_ADDR_DATA);
  assign ptr_wr = wr_en && (addr == TSP_ADDR_PTR);
  assign stat_wr = wr_en && (addr == TSP_ADDR_STAT);
  assign stat_rd = rd_en && (addr == TSP_ADDR_STAT);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic set_err;
    set_err = 1'b0;
    state_next = state_reg;
    state_next.rdata = '0;

    // The pointer changes only on its own write; data accesses leave it alone.
    if (ptr_wr)
    begin
      state_next.ptr = wr_data[TSP_PTR_W-1:0]; // RULE10 RULE9
    end

    // Fresh samples are stored as given: signed whole-value Celsius code.
    if (temp_valid)
    begin
      state_next.temp = temp_sample; // RULE8 RULE5 RULE4
    end

    // The data window follows the pointer for writes.
    if (data_wr)
    begin
      case (state_reg.ptr) // RULE1 RULE7
        TSP_PTR_CFG:
        begin
          state_next.cfg = wr_data[TSP_CFG_W-1:0]; // RULE2
        end
        TSP_PTR_UPPER:
        begin
          state_next.upper = wr_data; // RULE8 RULE3
        end
        TSP_PTR_LOWER:
        begin
          state_next.lower = wr_data; // RULE8
        end
        default:
        begin
          // Temperature is read-only and codes from 4 up are reserved.
          set_err = 1'b1;
        end
      endcase
    end

    // The data window follows the pointer for reads.
    if (data_rd)
    begin
      case (state_reg.ptr) // RULE1 RULE6
        TSP_PTR_TEMP:
        begin
          state_next.rdata = state_reg.temp; // RULE8 RULE3
        end
        TSP_PTR_CFG:
        begin
          state_next.rdata = {{(DATA_W-TSP_CFG_W){1'b0}}, state_reg.cfg}; // RULE2
        end
        TSP_PTR_UPPER:
        begin
          state_next.rdata = state_reg.upper;
        end
        TSP_PTR_LOWER:
        begin
          state_next.rdata = state_reg.lower;
        end
        default:
        begin
          set_err = 1'b1;
        end
      endcase
    end

    if (stat_rd)
    begin
      state_next.rdata[TSP_STAT_ERR_BIT] = state_reg.err;
      state_next.rdata[TSP_STAT_OVER_BIT] = state_reg.over;
      state_next.rdata[TSP_STAT_UNDER_BIT] = state_reg.under;
      state_next.rdata[TSP_STAT_WIDTH_LSB +: 5] = tsp_width_code(state_reg.ptr); // RULE2
    end

    // A write of one clears the error, but a new error in that cycle wins.
    if (stat_wr && wr_data[TSP_STAT_ERR_BIT])
    begin
      state_next.err = 1'b0;
    end
    if (set_err)
    begin
      state_next.err = 1'b1; // RULE1
    end

    // Limits compare as signed values so that sub-zero readings order correctly.
    state_next.over = $signed(state_reg.temp) > $signed(state_reg.upper); // RULE4
    state_next.under = $signed(state_reg.temp) < $signed(state_reg.lower); // RULE4
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg.ptr <= TSP_PTR_RST;
      state_reg.temp <= TSP_TEMP_RST;
      state_reg.cfg <= TSP_CFG_RST;
      state_reg.upper <= TSP_UPPER_RST;
      state_reg.lower <= TSP_LOWER_RST;
      state_reg.rdata <= '0;
      state_reg.err <= 1'b0;
      state_reg.over <= 1'b0;
      state_reg.under <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign rd_data = state_reg.rdata;
  assign over_temp = state_reg.over;
  assign under_temp = state_reg.under;
  assign access_err = state_reg.err;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_ptr_hold;
    !ptr_wr |=> $stable(state_reg.ptr);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) // RULE10
    else $error("pointer changed without a pointer write");

  property p_read_temp;
    data_rd && (state_reg.ptr == TSP_PTR_TEMP) |=> rd_data == $past(state_reg.temp);
  endproperty
  a_read_temp: assert property (p_read_temp) // RULE6
    else $error("temperature read returned wrong data");

  property p_read_cfg;
    data_rd && (state_reg.ptr == TSP_PTR_CFG)
      |=> rd_data == {8'h00, $past(state_reg.cfg)};
  endproperty
  a_read_cfg: assert property (p_read_cfg) // RULE2
    else $error("config read is not an 8-bit value in the low byte");

  property p_read_upper_msb;
    data_rd && (state_reg.ptr == TSP_PTR_UPPER)
      |=> rd_data[15:8] == $past(state_reg.upper[15:8]);
  endproperty
  a_read_upper_msb: assert property (p_read_upper_msb) // RULE3
    else $error("upper limit high byte misplaced");

  property p_write_lower;
    data_wr && (state_reg.ptr == TSP_PTR_LOWER) |=> state_reg.lower == $past(wr_data);
  endproperty
  a_write_lower: assert property (p_write_lower) // RULE7
    else $error("lower limit not loaded by write");

  property p_temp_capture;
    temp_valid |=> state_reg.temp == $past(temp_sample);
  endproperty
  a_temp_capture: assert property (p_temp_capture) // RULE8
    else $error("temperature sample not captured");

  property p_over_signed;
    ($signed(state_reg.temp) > $signed(state_reg.upper)) |=> over_temp;
  endproperty
  a_over_signed: assert property (p_over_signed) // RULE4
    else $error("over-temperature flag missed a signed compare");

  // A status clear right after the bad access is legal, so it is left out here.
  property p_rsvd_err;
    (data_wr || data_rd) && !tsp_ptr_valid(state_reg.ptr) ##1 !stat_wr
      |-> access_err [*2];
  endproperty
  a_rsvd_err: assert property (p_rsvd_err) // RULE1
    else $error("reserved pointer access did not flag an error");

  property p_under_signed;
    ($signed(state_reg.temp) < $signed(state_reg.lower)) |=> under_temp;
  endproperty
  a_under_signed: assert property (p_under_signed) // RULE4
    else $error("under-temperature flag missed a signed compare");

  property p_read_upper;
    data_rd && (state_reg.ptr == TSP_PTR_UPPER) |=> rd_data == $past(state_reg.upper);
  endproperty
  a_read_upper: assert property (p_read_upper) // RULE6
    else $error("upper limit read returned wrong data");

  property p_read_lower;
    data_rd && (state_reg.ptr == TSP_PTR_LOWER) |=> rd_data == $past(state_reg.lower);
  endproperty
  a_read_lower: assert property (p_read_lower) // RULE6
    else $error("lower limit read returned wrong data");

  property p_write_upper;
    data_wr && (state_reg.ptr == TSP_PTR_UPPER) |=> state_reg.upper == $past(wr_data);
  endproperty
  a_write_upper: assert property (p_write_upper) // RULE7
    else $error("upper limit not loaded by write");

  property p_write_cfg;
    data_wr && (state_reg.ptr == TSP_PTR_CFG)
      |=> state_reg.cfg == $past(wr_data[TSP_CFG_W-1:0]);
  endproperty
  a_write_cfg: assert property (p_write_cfg) // RULE2
    else $error("config write did not load the low byte");

  property p_temp_read_only;
    data_wr && (state_reg.ptr == TSP_PTR_TEMP) && !temp_valid
      |=> $stable(state_reg.temp) && access_err;
  endproperty
  a_temp_read_only: assert property (p_temp_read_only) // RULE8
    else $error("temperature register accepted a host write");

  property p_ptr_load;
    ptr_wr |=> state_reg.ptr == $past(wr_data[TSP_PTR_W-1:0]);
  endproperty
  a_ptr_load: assert property (p_ptr_load) // RULE10
    else $error("pointer write did not load the new pointer");

  property p_rd_idle;
    !data_rd && !stat_rd |=> rd_data == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) // RULE6
    else $error("read data shown without a read");

  property p_stat_width_cfg;
    stat_rd && (state_reg.ptr == TSP_PTR_CFG)
      |=> rd_data[TSP_STAT_WIDTH_LSB +: 5] == TSP_WIDTH_CODE_CFG;
  endproperty
  a_stat_width_cfg: assert property (p_stat_width_cfg) // RULE2
    else $error("status does not report an 8-bit config register");

  property p_over_clear;
    !($signed(state_reg.temp) > $signed(state_reg.upper)) |=> !over_temp;
  endproperty
  a_over_clear: assert property (p_over_clear) // RULE4
    else $error("over-temperature flag set without cause");

  property p_under_clear;
    !($signed(state_reg.temp) < $signed(state_reg.lower)) |=> !under_temp;
  endproperty
  a_under_clear: assert property (p_under_clear) // RULE4
    else $error("under-temperature flag set without cause");

  property p_err_sticky;
    access_err && !(stat_wr && wr_data[TSP_STAT_ERR_BIT]) |=> access_err;
  endproperty
  a_err_sticky: assert property (p_err_sticky) // RULE1
    else $error("access error dropped without a clear");

  c_ptr_then_read: cover property (ptr_wr ##1 data_rd ##1 1'b1);
  c_write_upper: cover property (data_wr && (state_reg.ptr == TSP_PTR_UPPER));
  c_over_flag: cover property ($rose(over_temp));
  c_err_clear: cover property (access_err ##1 stat_wr ##1 !access_err);

endmodule // tsp_regs

/* File: common/tsp_pkg.sv */
// Constants for the pointer-addressed thermometer register block.
package tsp_pkg;

  // ----------------------------------------
  // Host port addresses
  // ----------------------------------------
  localparam int TSP_ADDR_W = 2;
  localparam logic [1:0] TSP_ADDR_PTR = 2'h0;
  localparam logic [1:0] TSP_ADDR_DATA = 2'h1;
  localparam logic [1:0] TSP_ADDR_STAT = 2'h2;

  // ----------------------------------------
  // Pointer codes of the internal registers
  // ----------------------------------------
  localparam int TSP_PTR_W = 8;
  localparam logic [7:0] TSP_PTR_TEMP = 8'h00;
  localparam logic [7:0] TSP_PTR_CFG = 8'h01;
  localparam logic [7:0] TSP_PTR_UPPER = 8'h02;
  localparam logic [7:0] TSP_PTR_LOWER = 8'h03;
  localparam logic [7:0] TSP_PTR_FIRST_RSVD = 8'h04;

  // ----------------------------------------
  // Widths of the internal registers
  // ----------------------------------------
  localparam int TSP_WIDE_W = 16;
  localparam int TSP_CFG_W = 8;
  localparam logic [4:0] TSP_WIDTH_CODE_CFG = 5'h08;
  localparam logic [4:0] TSP_WIDTH_CODE_WIDE = 5'h10;
  localparam logic [4:0] TSP_WIDTH_CODE_NONE = 5'h00;

  // ----------------------------------------
  // Status word layout
  // ----------------------------------------
  localparam int TSP_STAT_ERR_BIT = 0;
  localparam int TSP_STAT_OVER_BIT = 1;
  localparam int TSP_STAT_UNDER_BIT = 2;
  localparam int TSP_STAT_WIDTH_LSB = 8;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] TSP_TEMP_RST = 16'h0000;
  localparam logic [7:0] TSP_CFG_RST = 8'h00;
  localparam logic [15:0] TSP_UPPER_RST = 16'h7fff;
  localparam logic [15:0] TSP_LOWER_RST = 16'h8000;
  localparam logic [7:0] TSP_PTR_RST = 8'h00;

endpackage

/* File: sim/tsp_sensor_model.sv */
// Behavioural model of the sensor that feeds measured temperatures to the register block.
`timescale 1ns/1ps

module tsp_sensor_model
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Bench request
  input wire logic load,
  input wire logic [15:0] value,
  // Measurement output
  output logic [15:0] temp_sample,
  output logic temp_valid
);
  // Outside a sample the bus inverts every cycle, so it alternates between the last value and its inverse.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      temp_sample <= 16'h0000;
      temp_valid <= 1'b0;
    end
    else if (load)
    begin
      temp_sample <= value;
      temp_valid <= 1'b1;
    end
    else
    begin
      temp_sample <= ~temp_sample;
      temp_valid <= 1'b0;
    end
  end
endmodule // tsp_sensor_model

/* File: sim/tb_top.sv */
// Self-checking bench of the pointer-addressed thermometer registers.
`timescale 1ns/1ps

module tb_top;
  import tsp_pkg::*;
  logic sys_clk, reset, wr_en, rd_en, load, temp_valid, over_temp, under_temp, access_err;
  logic rd_q = 1'b0;
  logic [1:0] addr;
  logic [15:0] wr_data, rd_data, temp_sample, load_val, v;
  logic [15:0] exp_q[$];
  logic [31:0] seed;
  int bad_count, check_count;
  localparam logic [15:0] RST_VAL[4] = '{TSP_TEMP_RST, {8'h00, TSP_CFG_RST}, TSP_UPPER_RST,
    TSP_LOWER_RST};

  tsp_regs dut (.sys_clk(sys_clk), .reset(reset), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .temp_sample(temp_sample),
    .temp_valid(temp_valid), .over_temp(over_temp), .under_temp(under_temp),
    .access_err(access_err));
  tsp_sensor_model sensor (.sys_clk(sys_clk), .reset(reset), .load(load), .value(load_val),
    .temp_sample(temp_sample), .temp_valid(temp_valid));

  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction

  task automatic check(logic [15:0] seen, logic [15:0] want);
    check_count++;
    if (seen !== want)
    begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic wr(logic [1:0] a, logic [15:0] d);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(logic [1:0] a, logic [15:0] want);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    addr <= a;
    exp_q.push_back(want);
    @(posedge sys_clk);
    rd_en <= 1'b0;
  endtask

  task automatic meas(logic [15:0] t);
    @(posedge sys_clk);
    load <= 1'b1;
    load_val <= t;
    @(posedge sys_clk);
    load <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Read data monitor
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    if (rd_q)
    begin
      if (exp_q.size() == 0)
        check(rd_data, 16'hdead);
      else
        check(rd_data, exp_q.pop_front());
    end
    rd_q <= rd_en;
  end

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // The whole run is about a hundred cycles; this limit of 20000 cycles leaves a wide margin.
  initial
  begin
    #80000;
    bad_count++;
    final_report();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    seed = 32'hc94c;
    {reset, wr_en, rd_en, load} = 4'b1000;
    addr = 2'h0;
    wr_data = 16'h0000;
    load_val = 16'h0000;
    bad_count = 0;
    check_count = 0;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    for (int p = 0; p < 4; p++)
    begin
      wr(TSP_ADDR_PTR, 16'(p));
      rd(TSP_ADDR_DATA, RST_VAL[p]);
      rd(TSP_ADDR_DATA, RST_VAL[p]);
    end
    for (int p = 1; p < 4; p++)
    begin
      v = rnd();
      wr(TSP_ADDR_PTR, 16'(p));
      wr(TSP_ADDR_DATA, v);
      rd(TSP_ADDR_DATA, (p == 1) ? {8'h00, v[7:0]} : v);
    end
    wr(TSP_ADDR_PTR, 16'h0002);
    wr(TSP_ADDR_DATA, 16'h0019);
    wr(TSP_ADDR_PTR, 16'h0003);
    wr(TSP_ADDR_DATA, 16'hfff6);
    meas(16'hffd8);
    @(negedge sys_clk) check({15'h0000, under_temp}, 16'h0001);
    wr(TSP_ADDR_PTR, 16'h0000);
    rd(TSP_ADDR_DATA, 16'hffd8);
    wr(TSP_ADDR_DATA, rnd());
    @(negedge sys_clk) check({15'h0000, access_err}, 16'h0001);
    rd(TSP_ADDR_DATA, 16'hffd8);
    rd(TSP_ADDR_STAT, 16'h1005);
    wr(TSP_ADDR_STAT, 16'h0001);
    wr(TSP_ADDR_PTR, 16'h0004);
    rd(TSP_ADDR_DATA, 16'h0000);
    rd(TSP_ADDR_STAT, 16'h0005);
    wr(TSP_ADDR_STAT, 16'h0001);
    @(negedge sys_clk) check({15'h0000, access_err}, 16'h0000);
    meas(16'h0032);
    wr(TSP_ADDR_PTR, 16'h0001);
    rd(TSP_ADDR_STAT, 16'h0802);
    @(negedge sys_clk) check({14'h0000, over_temp, under_temp}, 16'h0002);
    repeat (4) @(posedge sys_clk);
    final_report();
  end
endmodule // tb_top
